// [src/dato_alarm_torque_out.sv]
// module: alarm relay contacts and over-torque flag routing for a motor drive
// Contract
// - flag rises when estimated torque exceeds the applicable threshold
// - flag clears while estimated torque stays below the thresholds
// - four thresholds by quadrant, each zero to two hundred percent
// - flag routes to terminals 11-15 or relay when function code seven
// - flag meaningful only under the three vector control methods
// - comparison only monitors; it never limits produced torque
// - default polarity: first contact closed normal, swapped on trip or power loss
// - inverted polarity: first open normal, closed on trip; unpowered first open
// - normally closed alarm may take under two seconds to close at power-up
// - alarm output stays valid while control circuit keeps power
// - alarm-related output lags the fault alarm by nominal 300 ms
`timescale 1ns/1ns
`default_nettype none
module dato_alarm_torque_out
  import dato_pkg::*;
#(
  parameter int unsigned NUM_TERM = DATO_NUM_TERM,
  parameter int unsigned LAG_CYC = DATO_ALARM_LAG_CYC,
  parameter int unsigned START_CYC = DATO_NC_START_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // drive state, from pins
  input wire logic ctrl_power_ok_i,
  input wire logic trip_i,
  // operating point, same clock
  input wire logic dir_rev_i,
  input wire logic regen_i,
  input wire logic [dato_pkg::DATO_TRQ_W-1:0] torque_est_i,
  // configuration
  input wire logic [3:0] control_method_select_i,
  input wire logic alarm_polarity_select_i,
  input wire logic [dato_pkg::DATO_FN_W-1:0] alarm_relay_function_select_i,
  input wire logic [NUM_TERM*dato_pkg::DATO_FN_W-1:0] output_terminal_function_select_i,
  input wire logic [dato_pkg::DATO_PCT_W-1:0] torque_limit_fwd_drive_i,
  input wire logic [dato_pkg::DATO_PCT_W-1:0] torque_limit_rev_regen_i,
  input wire logic [dato_pkg::DATO_PCT_W-1:0] torque_limit_rev_drive_i,
  input wire logic [dato_pkg::DATO_PCT_W-1:0] torque_limit_fwd_regen_i,
  // outputs
  output logic over_torque_flag_o,
  output logic [NUM_TERM-1:0] output_terminal_o,
  output logic alarm_relay_first_contact_o,
  output logic alarm_relay_second_contact_o,
  output logic alarm_lagged_o
);
  import dato_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic pwr_s1_q;
  logic pwr_s2_q;
  logic trip_s1_q;
  logic trip_s2_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
      trip_s1_q <= 1'b0;
      trip_s2_q <= 1'b0;
    end
    else
    begin
      pwr_s1_q <= ctrl_power_ok_i;
      pwr_s2_q <= pwr_s1_q;
      trip_s1_q <= trip_i;
      trip_s2_q <= trip_s1_q;
    end
  end

  // ****************************************************************
  // over-torque detection
  // ****************************************************************
  logic over_raw;
  logic vector_mode;
  logic flag_q;

  dato_torque_cmp u_cmp (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .dir_rev_i(dir_rev_i),
    .regen_i(regen_i),
    .torque_est_i(torque_est_i),
    .torque_limit_fwd_drive_i(torque_limit_fwd_drive_i),
    .torque_limit_rev_regen_i(torque_limit_rev_regen_i),
    .torque_limit_rev_drive_i(torque_limit_rev_drive_i),
    .torque_limit_fwd_regen_i(torque_limit_fwd_regen_i),
    .over_q_o(over_raw),
    .quad_o()
  );

  assign vector_mode = (control_method_select_i == DATO_CM_SLV)
                    || (control_method_select_i == DATO_CM_SLV0HZ)
                    || (control_method_select_i == DATO_CM_VEC_SENSOR);

  // outside vector modes the estimate is meaningless, so the flag is held low
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      flag_q <= DATO_RST_FLAG;
    else
      flag_q <= over_raw && vector_mode;
  end

  assign over_torque_flag_o = flag_q;

  // ****************************************************************
  // alarm state and lag
  // ****************************************************************
  logic alarm_active;
  logic alarm_q;
  logic lag_done;
  logic lag_q;
  logic start_done;
  dato_al_state_t al_state_q;

  // fault alarm is trip, or loss of control power
  assign alarm_active = trip_s2_q || !pwr_s2_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      alarm_q <= DATO_RST_ALARM;
    else
      alarm_q <= alarm_active;
  end

  dato_lag_timer #(
    .CYCLES(LAG_CYC)
  ) u_lag (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .restart_i(alarm_q == lag_q),
    .done_o(lag_done)
  );

  // counter held clear while the copy agrees, so a short blip never passes
  // lagged copy only follows once alarm held steady for the lag
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      lag_q <= DATO_RST_ALARM;
    else if (lag_done)
      lag_q <= alarm_q;
  end

  assign alarm_lagged_o = lag_q;

  dato_lag_timer #(
    .CYCLES(START_CYC)
  ) u_start (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .restart_i(!pwr_s2_q),
    .done_o(start_done)
  );

  // power-up hold: contacts stay at their unpowered rest state
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      al_state_q <= DATO_AL_POWERUP;
    else
    begin
      unique case (al_state_q)
        DATO_AL_POWERUP: if (start_done) al_state_q <= DATO_AL_RUN;
        DATO_AL_RUN: if (!pwr_s2_q) al_state_q <= DATO_AL_POWERUP;
      endcase
    end
  end

  // ****************************************************************
  // relay function and contact drive
  // ****************************************************************
  logic relay_src;
  logic first_d;
  logic first_q;

  // relay carries either the fault alarm or the over-torque flag
  assign relay_src = (alarm_relay_function_select_i == DATO_FN_OVER_TORQUE)
                   ? flag_q : alarm_q;

  always_comb
  begin
    first_d = 1'b0;
    if (al_state_q == DATO_AL_POWERUP)
      first_d = 1'b0;
    else if (alarm_polarity_select_i == DATO_POL_DEFAULT)
      first_d = !relay_src;
    else
      first_d = relay_src;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      first_q <= 1'b0;
    else
      first_q <= first_d;
  end

  // single changeover contact: second is always the complement
  assign alarm_relay_first_contact_o = first_q;
  assign alarm_relay_second_contact_o = !first_q;

  // ****************************************************************
  // open-collector terminals
  // ****************************************************************
  logic [NUM_TERM-1:0] term_q;

  for (genvar t = 0; t < NUM_TERM; t++)
  begin : g_term
    logic [DATO_FN_W-1:0] fn;
    assign fn = output_terminal_function_select_i[t*DATO_FN_W +: DATO_FN_W];
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
      if (rst_i)
        term_q[t] <= 1'b0;
      else
        term_q[t] <= ((fn == DATO_FN_OVER_TORQUE) && flag_q)
                  || ((fn == DATO_FN_ALARM) && alarm_q);
    end
  end

  assign output_terminal_o = term_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  // cycles the alarm has differed from its lagged copy, for the lag checks
  logic [31:0] diff_cnt_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      diff_cnt_q <= '0;
    else if (alarm_q != lag_q)
      diff_cnt_q <= diff_cnt_q + 32'h1;
    else
      diff_cnt_q <= '0;
  end

  a_flag_mode_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !$past(vector_mode) |-> !flag_q)
    else $error("flag set outside vector mode");
  a_flag_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(over_raw) && $past(vector_mode)) |-> flag_q)
    else $error("flag missed over-torque");
  a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !$past(over_raw) |-> !flag_q)
    else $error("flag held without over-torque");
  a_relay_default: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(al_state_q) == DATO_AL_RUN && $past(alarm_polarity_select_i)
      && $past(alarm_relay_function_select_i) != DATO_FN_OVER_TORQUE)
    |-> first_q == !$past(alarm_q))
    else $error("default polarity contact wrong");
  a_relay_invert: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(al_state_q) == DATO_AL_RUN && !$past(alarm_polarity_select_i)
      && $past(alarm_relay_function_select_i) != DATO_FN_OVER_TORQUE)
    |-> first_q == $past(alarm_q))
    else $error("inverted polarity contact wrong");
  a_relay_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(al_state_q) == DATO_AL_RUN && $past(alarm_polarity_select_i)
      && $past(alarm_relay_function_select_i) == DATO_FN_OVER_TORQUE)
    |-> first_q == !$past(flag_q))
    else $error("relay flag route wrong");
  a_relay_unpowered: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $past(al_state_q) == DATO_AL_POWERUP |-> !first_q && alarm_relay_second_contact_o)
    else $error("unpowered contact state wrong");
  a_power_loss_rest: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !pwr_s2_q |-> ##2 !first_q)
    else $error("contact not at rest after power loss");
  a_contact_exclusive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    alarm_relay_first_contact_o != alarm_relay_second_contact_o)
    else $error("contacts not complementary");
  a_lag_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (lag_q != alarm_q) ##1 (lag_q != alarm_q) |-> $stable(lag_q))
    else $error("lagged alarm moved early");
  a_lag_min: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $changed(lag_q) |-> $past(diff_cnt_q) >= 32'(LAG_CYC))
    else $error("lagged alarm followed too soon");
  a_lag_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    diff_cnt_q <= 32'(LAG_CYC) + 32'h1)
    else $error("lagged alarm followed too late");
  a_term_route: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(output_terminal_function_select_i[DATO_FN_W-1:0]) == DATO_FN_OVER_TORQUE)
    |-> term_q[0] == $past(flag_q))
    else $error("terminal routing wrong");

  c_flag_rise: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(flag_q));
  c_trip_swap: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(alarm_q) ##1 $fell(first_q));
  c_lag_follow: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(lag_q));
  c_run_state: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    $past(al_state_q) == DATO_AL_POWERUP && al_state_q == DATO_AL_RUN);
endmodule : dato_alarm_torque_out
`default_nettype wire

// [src/dato_lag_timer.sv]
// module: settable cycle counter used for alarm lag and start delay
`timescale 1ns/1ns
`default_nettype none
module dato_lag_timer #(
  parameter int unsigned CYCLES = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // control
  input wire logic restart_i,
  // status
  output logic done_o
);
  localparam int unsigned CNT_W = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CYCLES);

  logic [CNT_W-1:0] cnt_q;

  // ****************************************************************
  // counter: restart clears, then counts up and saturates
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (restart_i)
      cnt_q <= '0;
    else if (cnt_q != CNT_MAX)
      cnt_q <= cnt_q + CNT_W'(1);
  end

  assign done_o = (cnt_q == CNT_MAX);
endmodule : dato_lag_timer
`default_nettype wire

// [src/dato_pkg.sv]
// package: constants and types for the alarm relay and over-torque output block
package dato_pkg;
  // ****************************************************************
  // widths and codes
  // ****************************************************************
  localparam int unsigned DATO_PCT_W = 8;
  localparam int unsigned DATO_TRQ_W = 9;
  localparam int unsigned DATO_FN_W = 6;
  localparam int unsigned DATO_NUM_TERM = 5;
  localparam logic [DATO_PCT_W-1:0] DATO_PCT_MAX = 8'hc8;
  localparam logic [DATO_FN_W-1:0] DATO_FN_OVER_TORQUE = 6'h07;
  localparam logic [DATO_FN_W-1:0] DATO_FN_ALARM = 6'h05;
  localparam logic [1:0] DATO_CTRL_SLV = 2'h3;
  localparam logic [3:0] DATO_CM_SLV = 4'h3;
  localparam logic [3:0] DATO_CM_SLV0HZ = 4'h4;
  localparam logic [3:0] DATO_CM_VEC_SENSOR = 4'h5;
  localparam logic DATO_POL_INVERTED = 1'b0;
  localparam logic DATO_POL_DEFAULT = 1'b1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic DATO_RST_FLAG = 1'b0;
  localparam logic DATO_RST_ALARM = 1'b0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned DATO_CLK_MHZ = 125;
  localparam int unsigned DATO_ALARM_LAG_MS = 300;
  localparam int unsigned DATO_NC_START_MS = 1900;
  localparam int unsigned DATO_ALARM_LAG_CYC = DATO_ALARM_LAG_MS * 1000 * DATO_CLK_MHZ;
  localparam int unsigned DATO_NC_START_CYC = DATO_NC_START_MS * 1000 * DATO_CLK_MHZ;

  typedef enum logic [1:0] {
    DATO_Q_FWD_DRIVE,
    DATO_Q_REV_REGEN,
    DATO_Q_REV_DRIVE,
    DATO_Q_FWD_REGEN
  } dato_quad_t;

  typedef enum logic [1:0] {
    DATO_AL_POWERUP,
    DATO_AL_RUN
  } dato_al_state_t;
endpackage : dato_pkg

// [src/dato_torque_cmp.sv]
// module: per-quadrant over-torque threshold select and compare
`timescale 1ns/1ns
`default_nettype none
module dato_torque_cmp
  import dato_pkg::*;
#(
  parameter int unsigned PCT_W = DATO_PCT_W,
  parameter int unsigned TRQ_W = DATO_TRQ_W
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // operating point
  input wire logic dir_rev_i,
  input wire logic regen_i,
  input wire logic [TRQ_W-1:0] torque_est_i,
  // thresholds
  input wire logic [PCT_W-1:0] torque_limit_fwd_drive_i,
  input wire logic [PCT_W-1:0] torque_limit_rev_regen_i,
  input wire logic [PCT_W-1:0] torque_limit_rev_drive_i,
  input wire logic [PCT_W-1:0] torque_limit_fwd_regen_i,
  // result
  output logic over_q_o,
  output dato_pkg::dato_quad_t quad_o
);
  import dato_pkg::*;

  dato_quad_t quad_d;
  logic [PCT_W-1:0] lim_d;
  logic [PCT_W-1:0] lim_clip;
  logic over_q;
  dato_quad_t quad_q;

  // ****************************************************************
  // quadrant pick
  // ****************************************************************
  always_comb
  begin
    quad_d = DATO_Q_FWD_DRIVE;
    unique case ({dir_rev_i, regen_i})
      2'b00: quad_d = DATO_Q_FWD_DRIVE;
      2'b01: quad_d = DATO_Q_FWD_REGEN;
      2'b10: quad_d = DATO_Q_REV_DRIVE;
      2'b11: quad_d = DATO_Q_REV_REGEN;
    endcase
  end

  always_comb
  begin
    lim_d = torque_limit_fwd_drive_i;
    unique case (quad_d)
      DATO_Q_FWD_DRIVE: lim_d = torque_limit_fwd_drive_i;
      DATO_Q_REV_REGEN: lim_d = torque_limit_rev_regen_i;
      DATO_Q_REV_DRIVE: lim_d = torque_limit_rev_drive_i;
      DATO_Q_FWD_REGEN: lim_d = torque_limit_fwd_regen_i;
    endcase
  end

  // settings above full scale clip to the top of the range
  assign lim_clip = (lim_d > PCT_W'(DATO_PCT_MAX)) ? PCT_W'(DATO_PCT_MAX) : lim_d;

  // ****************************************************************
  // compare: monitoring only, nothing feeds back to torque
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      over_q <= DATO_RST_FLAG;
      quad_q <= DATO_Q_FWD_DRIVE;
    end
    else
    begin
      over_q <= (torque_est_i > TRQ_W'(lim_clip));
      quad_q <= quad_d;
    end
  end

  assign over_q_o = over_q;
  assign quad_o = quad_q;

  a_cmp_over_track: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    1'b1 |=> over_q == $past(torque_est_i > TRQ_W'(lim_clip)))
    else $error("over-torque compare wrong");
  a_cmp_quad_pick: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(dir_rev_i) && !$past(regen_i)) |-> quad_q == DATO_Q_REV_DRIVE)
    else $error("quadrant pick wrong");
endmodule : dato_torque_cmp
`default_nettype wire

// [testbench/dato_ctrl_reader.sv]
// partner: external control circuit reading the relay contacts and open-collector terminals
`timescale 1ns/1ns
`default_nettype none
module dato_ctrl_reader #(
  parameter int unsigned NUM_TERM = 5
) (
  // from the block
  input wire logic [NUM_TERM-1:0] term_on_i,
  input wire logic first_closed_i,
  input wire logic second_closed_i,
  // what the controller sees
  output logic [NUM_TERM-1:0] term_level_o,
  output logic contact_clash_o
);
  // pull-up on each terminal; an active open collector pulls it low
  assign term_level_o = ~term_on_i;
  // a changeover contact never shows both or neither closed
  assign contact_clash_o = first_closed_i == second_closed_i;
endmodule : dato_ctrl_reader
`default_nettype wire

// [testbench/drive_alarm_torque_outputs_tb.sv]
// testbench: alarm relay, terminals and over-torque flag
`timescale 1ns/1ns
`default_nettype none
module drive_alarm_torque_outputs_tb;
  import dato_pkg::*;
  localparam int unsigned NT = 5;
  logic ref_clk_i, rst_i, pwr, trip, dir_rev, regen, pol;
  logic [DATO_TRQ_W-1:0] trq;
  logic [3:0] cm;
  logic [DATO_FN_W-1:0] relay_fn;
  logic [NT*DATO_FN_W-1:0] term_fn;
  logic [DATO_PCT_W-1:0] lim [4];
  logic flag, first, second, lagged, clash;
  logic [NT-1:0] term, term_lvl;
  int miscompares, samples_checked, cycles;
  // quadrant table in package order: fwd drive, rev regen, rev drive, fwd regen
  logic qdir [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic qreg [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  dato_alarm_torque_out #(.NUM_TERM(NT), .LAG_CYC(8), .START_CYC(8)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ctrl_power_ok_i(pwr), .trip_i(trip),
    .dir_rev_i(dir_rev), .regen_i(regen), .torque_est_i(trq),
    .control_method_select_i(cm), .alarm_polarity_select_i(pol),
    .alarm_relay_function_select_i(relay_fn), .output_terminal_function_select_i(term_fn),
    .torque_limit_fwd_drive_i(lim[0]), .torque_limit_rev_regen_i(lim[1]),
    .torque_limit_rev_drive_i(lim[2]), .torque_limit_fwd_regen_i(lim[3]),
    .over_torque_flag_o(flag), .output_terminal_o(term),
    .alarm_relay_first_contact_o(first), .alarm_relay_second_contact_o(second),
    .alarm_lagged_o(lagged)
  );

  dato_ctrl_reader #(.NUM_TERM(NT)) u_reader (
    .term_on_i(term), .first_closed_i(first), .second_closed_i(second),
    .term_level_o(term_lvl), .contact_clash_o(clash)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick

  task automatic chk(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_relay(input logic exp_first, input string what);
    chk(first, exp_first, what);
    chk(second, ~exp_first, what);
    chk(clash, 1'b0, what);
  endtask : chk_relay

  task automatic chk_term(input logic [NT-1:0] exp);
    samples_checked++;
    if (term !== exp || term_lvl !== ~exp)
    begin
      miscompares++;
      $display("wrong value at %0t: terminals got %b exp %b", $time, term, exp);
    end
  endtask : chk_term

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // clock and timeout
  // ****************************************************************
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    rst_i = 1'b1;
    pwr = 1'b0;
    trip = 1'b0;
    dir_rev = 1'b0;
    regen = 1'b0;
    pol = DATO_POL_DEFAULT;
    trq = 9'h000;
    cm = DATO_CM_SLV;
    relay_fn = DATO_FN_ALARM;
    // terminal 11 flag, 12 alarm, 13 flag, 14 unused, 15 flag
    term_fn = {DATO_FN_OVER_TORQUE, 6'h00, DATO_FN_OVER_TORQUE, DATO_FN_ALARM,
               DATO_FN_OVER_TORQUE};
    lim = '{8'h0a, 8'h14, 8'h1e, 8'h28};
    tick(2);
    rst_i = 1'b0;
    chk_relay(1'b0, "unpowered");
    pwr = 1'b1;
    tick(4);
    chk_relay(1'b0, "start hold");
    tick(20);
    chk_relay(1'b1, "normal");
    $display("test power_up done");

    for (int q = 0; q < 4; q++)
    begin
      dir_rev = qdir[q];
      regen = qreg[q];
      trq = {1'b0, lim[q]};
      tick(4);
      chk(flag, 1'b0, "flag at limit");
      trq = {1'b0, lim[q]} + 9'h001;
      tick(4);
      chk(flag, 1'b1, "flag above limit");
      chk_term(5'h15);
      chk_relay(1'b1, "relay ignores flag");
    end
    $display("test quadrants done");

    dir_rev = 1'b0;
    regen = 1'b0;
    lim[0] = 8'hff;
    trq = 9'h0c8;
    tick(4);
    chk(flag, 1'b0, "clipped limit");
    trq = 9'h0c9;
    tick(4);
    chk(flag, 1'b1, "above clipped limit");
    lim[0] = 8'h0a;
    $display("test clip done");

    for (int m = 0; m < 16; m++)
    begin
      cm = m[3:0];
      tick(4);
      chk(flag, m inside {3, 4, 5}, "control method");
    end
    cm = DATO_CM_VEC_SENSOR;
    $display("test methods done");

    relay_fn = DATO_FN_OVER_TORQUE;
    tick(6);
    chk_relay(1'b0, "relay shows flag");
    trq = 9'h000;
    tick(6);
    chk_relay(1'b1, "relay flag clear");
    relay_fn = DATO_FN_ALARM;
    $display("test relay_flag done");

    trip = 1'b1;
    tick(6);
    chk(lagged, 1'b0, "lag early");
    chk_relay(1'b0, "trip default");
    chk_term(5'h02);
    tick(12);
    chk(lagged, 1'b1, "lag late");
    pol = DATO_POL_INVERTED;
    tick(4);
    chk_relay(1'b1, "trip inverted");
    trip = 1'b0;
    tick(6);
    chk_relay(1'b0, "normal inverted");
    pwr = 1'b0;
    tick(6);
    chk_relay(1'b0, "unpowered inverted");
    pol = DATO_POL_DEFAULT;
    tick(4);
    chk_relay(1'b0, "unpowered default");
    pwr = 1'b1;
    tick(30);
    chk_relay(1'b1, "power back");
    chk(lagged, 1'b0, "lag clear");
    $display("test trip_polarity done");
    end_of_test();
  end
endmodule : drive_alarm_torque_outputs_tb
`default_nettype wire
